// ===== rtl/cpm_pkg.sv
// package: constants and types for the call-progress monitor output block
// Contract
// - rx and tx contributions scaled linearly by attenuators
// - attenuator of zero fully mutes its contribution
// - attenuators never touch line-side rx or tx
// - mode field sits in bits 5:4 of control
// - modes: delta-sigma, 32 kHz rz pwm, balanced pwm
package cpm_pkg;

	// ==========================================================
	// timing
	localparam int CPM_CLK_HZ = 200_000_000;
	localparam int CPM_PWM_HZ = 32_000;
	localparam int CPM_PWM_PERIOD_CYC = CPM_CLK_HZ / CPM_PWM_HZ;

	// ==========================================================
	// register indices (byte address is four times the index)
	localparam logic [7:0] CPM_IDX_OUT_CTRL = 8'h01;
	localparam logic [7:0] CPM_IDX_INT_CTRL = 8'h02;
	localparam logic [7:0] CPM_IDX_RX_ATT = 8'h14;
	localparam logic [7:0] CPM_IDX_TX_ATT = 8'h15;
	localparam logic [7:0] CPM_IDX_STATUS = 8'h16;

	// ==========================================================
	// field positions and reset values
	localparam int CPM_MODE_LSB = 4;
	localparam int CPM_PWM_EN_BIT = 3;
	localparam int CPM_INT_EN_BIT = 0;
	localparam int CPM_STAT_PIN_BIT = 0;
	localparam int CPM_STAT_ACT_BIT = 1;
	localparam logic [7:0] CPM_OUT_CTRL_RST = 8'h00;
	localparam logic [7:0] CPM_INT_CTRL_RST = 8'h00;
	localparam logic [7:0] CPM_ATT_RST = 8'h00;
	localparam int CPM_ATT_SHIFT = 8;

	// ==========================================================
	// types
	typedef enum logic [1:0] {
		CPM_MODE_RZ = 2'b00,
		CPM_MODE_BAL = 2'b01,
		CPM_MODE_DS = 2'b10,
		CPM_MODE_OFF = 2'b11
	} cpm_mode_t;

	typedef struct packed {
		logic en;
		cpm_mode_t mode;
	} cpm_mod_cfg_t;

endpackage : cpm_pkg

// ===== rtl/cpm_modulator.sv
// modulator: delta-sigma, return-to-zero pwm and balanced pwm
`timescale 1ns/1ps
module cpm_modulator #(
	parameter int SW = 16,
	parameter int CW = 16,
	parameter int PERIOD = cpm_pkg::CPM_PWM_PERIOD_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire cpm_pkg::cpm_mod_cfg_t cfg,
	input wire logic signed [SW-1:0] sample,
	output logic out_bit
);
	import cpm_pkg::*;

	localparam logic [CW-1:0] PER = CW'(PERIOD);
	localparam logic [CW-1:0] PER_M1 = CW'(PERIOD - 1);

	logic [SW-1:0] level;
	logic [SW+CW-1:0] prod;
	logic [CW-1:0] cnt_reg;
	logic [CW-1:0] duty_reg;
	logic [CW-1:0] lo_edge;
	logic [CW-1:0] hi_edge;
	logic [SW-1:0] acc_reg;
	logic [SW:0] acc_sum;
	logic out_next;

	// ==========================================================
	// offset binary level and duty
	assign level = {~sample[SW-1], sample[SW-2:0]};
	assign prod = level * PER;
	assign lo_edge = (PER - duty_reg) >> 1;
	assign hi_edge = lo_edge + duty_reg;
	assign acc_sum = {1'b0, acc_reg} + {1'b0, level};

	// ==========================================================
	// period counter, 32 kHz frame
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= '0;
		end else if (!cfg.en || cnt_reg == PER_M1) begin
			cnt_reg <= '0;
		end else begin
			cnt_reg <= cnt_reg + 1'b1;
		end
	end

	// duty changes only at a frame boundary or while disabled, so no glitch pulses
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			duty_reg <= '0;
		end else if (!cfg.en || cnt_reg == PER_M1) begin
			duty_reg <= prod[SW+CW-1:SW];
		end
	end

	// first-order delta-sigma accumulator, runs at full clock
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			acc_reg <= '0;
		end else if (!cfg.en) begin
			acc_reg <= '0;
		end else begin
			acc_reg <= acc_sum[SW-1:0];
		end
	end

	always_comb begin
		out_next = 1'b0;
		unique case (cfg.mode)
			CPM_MODE_RZ: out_next = cnt_reg < duty_reg;
			CPM_MODE_BAL: out_next = cnt_reg >= lo_edge && cnt_reg < hi_edge;
			CPM_MODE_DS: out_next = acc_sum[SW];
			CPM_MODE_OFF: out_next = 1'b0;
		endcase
		if (!cfg.en) begin
			out_next = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			out_bit <= 1'b0;
		end else begin
			out_bit <= out_next;
		end
	end

	// ==========================================================
	// checks
	frame_wrap_a: assert property (@(posedge clk) disable iff (!rst_n)
		cfg.en && cnt_reg == PER_M1 |=> cnt_reg == '0)
		else $error("frame counter did not wrap at period end");
	rz_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
		cfg.en && cfg.mode == CPM_MODE_RZ && cnt_reg >= duty_reg |=> !out_bit)
		else $error("rz pwm high past its duty");
	bal_start_a: assert property (@(posedge clk) disable iff (!rst_n)
		cfg.en && cfg.mode == CPM_MODE_BAL && cnt_reg == '0 && duty_reg < PER - 2
		|=> !out_bit)
		else $error("balanced pwm not low at frame start");

	cover_rz_c: cover property (@(posedge clk) disable iff (!rst_n)
		cfg.en && cfg.mode == CPM_MODE_RZ && out_bit ##1 !out_bit);
	cover_bal_c: cover property (@(posedge clk) disable iff (!rst_n)
		cfg.en && cfg.mode == CPM_MODE_BAL && out_bit);
	cover_ds_c: cover property (@(posedge clk) disable iff (!rst_n)
		cfg.en && cfg.mode == CPM_MODE_DS && out_bit ##1 !out_bit);

endmodule : cpm_modulator

// ===== rtl/cpm_monitor_top.sv
// top: apb registers, monitor mix, attenuators and aux pin mux
`timescale 1ns/1ps
module cpm_monitor_top #(
	parameter int SW = 16,
	parameter int AW = 8,
	parameter int PWM_PERIOD_CYC = cpm_pkg::CPM_PWM_PERIOD_CYC
) (
	input wire logic SYS_CLK,
	input wire logic RST_N,
	input wire logic [9:0] PADDR,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic signed [SW-1:0] RX_SAMPLE,
	input wire logic signed [SW-1:0] TX_SAMPLE,
	input wire logic IRQ_IN,
	output logic signed [SW-1:0] RX_LINE_OUT,
	output logic signed [SW-1:0] TX_LINE_OUT,
	output logic AUXILIARY_MONITOR_OUTPUT
);
	import cpm_pkg::*;

	logic [7:0] out_ctrl_reg;
	logic [7:0] int_ctrl_reg;
	logic [AW-1:0] rx_att_reg;
	logic [AW-1:0] tx_att_reg;
	logic signed [SW+AW:0] rx_prod;
	logic signed [SW+AW:0] tx_prod;
	logic signed [SW:0] rx_part;
	logic signed [SW:0] tx_part;
	logic signed [SW+1:0] mix_sum;
	logic signed [SW-1:0] mix_next;
	logic signed [SW-1:0] mix_reg;
	logic mod_bit;
	logic aux_next;
	cpm_mod_cfg_t mod_cfg;
	logic pwm_en;
	logic int_en;
	logic acc_phase;
	logic wr_fire;
	logic hit;
	logic [31:0] rd_data;

	// ==========================================================
	// apb slave: one wait state, write lands with pready
	assign pwm_en = out_ctrl_reg[CPM_PWM_EN_BIT];
	assign int_en = int_ctrl_reg[CPM_INT_EN_BIT];
	assign acc_phase = PSEL && PENABLE;
	assign wr_fire = acc_phase && PREADY && PWRITE && hit;

	always_comb begin
		hit = PADDR[1:0] == 2'b00;
		rd_data = 32'h0000_0000;
		unique case (PADDR[9:2])
			CPM_IDX_OUT_CTRL: rd_data[7:0] = out_ctrl_reg;
			CPM_IDX_INT_CTRL: rd_data[7:0] = int_ctrl_reg;
			CPM_IDX_RX_ATT: rd_data[AW-1:0] = rx_att_reg;
			CPM_IDX_TX_ATT: rd_data[AW-1:0] = tx_att_reg;
			CPM_IDX_STATUS: begin
				rd_data[CPM_STAT_PIN_BIT] = AUXILIARY_MONITOR_OUTPUT;
				rd_data[CPM_STAT_ACT_BIT] = mod_cfg.en;
			end
			default: hit = 1'b0;
		endcase
	end

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			PREADY <= 1'b0;
			PSLVERR <= 1'b0;
			PRDATA <= 32'h0000_0000;
		end else begin
			PREADY <= acc_phase && !PREADY;
			PSLVERR <= acc_phase && !PREADY && !hit;
			PRDATA <= (acc_phase && !PREADY && !PWRITE && hit) ? rd_data : 32'h0000_0000;
		end
	end

	// ==========================================================
	// control and attenuation registers
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			out_ctrl_reg <= CPM_OUT_CTRL_RST;
			int_ctrl_reg <= CPM_INT_CTRL_RST;
			rx_att_reg <= CPM_ATT_RST[AW-1:0];
			tx_att_reg <= CPM_ATT_RST[AW-1:0];
		end else if (wr_fire) begin
			unique case (PADDR[9:2])
				CPM_IDX_OUT_CTRL: out_ctrl_reg <= PWDATA[7:0];
				CPM_IDX_INT_CTRL: int_ctrl_reg <= PWDATA[7:0];
				CPM_IDX_RX_ATT: rx_att_reg <= PWDATA[AW-1:0];
				CPM_IDX_TX_ATT: tx_att_reg <= PWDATA[AW-1:0];
				default: ;
			endcase
		end
	end

	// ==========================================================
	// monitor mix: linear gain att/256, zero mutes exactly
	assign rx_prod = RX_SAMPLE * $signed({1'b0, rx_att_reg});
	assign tx_prod = TX_SAMPLE * $signed({1'b0, tx_att_reg});
	assign rx_part = rx_prod[SW+AW:CPM_ATT_SHIFT];
	assign tx_part = tx_prod[SW+AW:CPM_ATT_SHIFT];
	assign mix_sum = {rx_part[SW], rx_part} + {tx_part[SW], tx_part};

	// saturate rather than wrap, a wrap would click in the speaker
	always_comb begin
		mix_next = mix_sum[SW-1:0];
		if (mix_sum > $signed({3'b000, {(SW-1){1'b1}}})) begin
			mix_next = {1'b0, {(SW-1){1'b1}}};
		end else if (mix_sum < $signed({3'b111, {(SW-1){1'b0}}})) begin
			mix_next = {1'b1, {(SW-1){1'b0}}};
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			mix_reg <= '0;
		end else begin
			mix_reg <= mix_next;
		end
	end

	// line path is a plain register stage, attenuators not in it
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			RX_LINE_OUT <= '0;
			TX_LINE_OUT <= '0;
		end else begin
			RX_LINE_OUT <= RX_SAMPLE;
			TX_LINE_OUT <= TX_SAMPLE;
		end
	end

	// ==========================================================
	// modulator and shared pin
	assign mod_cfg = '{en: pwm_en && !int_en,
		mode: cpm_mode_t'(out_ctrl_reg[CPM_MODE_LSB+1:CPM_MODE_LSB])};

	cpm_modulator #(
		.SW(SW),
		.CW(16),
		.PERIOD(PWM_PERIOD_CYC)
	) u_mod (
		.clk(SYS_CLK),
		.rst_n(RST_N),
		.cfg(mod_cfg),
		.sample(mix_reg),
		.out_bit(mod_bit)
	);

	// interrupt function owns the pin while enabled
	always_comb begin
		aux_next = 1'b0;
		if (int_en) begin
			aux_next = IRQ_IN;
		end else if (pwm_en) begin
			aux_next = mod_bit;
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			AUXILIARY_MONITOR_OUTPUT <= 1'b0;
		end else begin
			AUXILIARY_MONITOR_OUTPUT <= aux_next;
		end
	end

	// ==========================================================
	// checks
	mode_write_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		wr_fire && PADDR[9:2] == CPM_IDX_OUT_CTRL
		|=> mod_cfg.mode == cpm_mode_t'($past(PWDATA[CPM_MODE_LSB+1:CPM_MODE_LSB])))
		else $error("mode field not taken from bits 5:4");
	mute_both_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(rx_att_reg == '0 && tx_att_reg == '0) [*2] |-> mix_reg == '0)
		else $error("muted monitor mix not zero");
	rx_only_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		tx_att_reg == '0 |=> mix_reg == $past(rx_part[SW-1:0]))
		else $error("rx contribution not scaled linearly");
	line_pass_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		RST_N |=> (RX_LINE_OUT == $past(RX_SAMPLE) && TX_LINE_OUT == $past(TX_SAMPLE)))
		else $error("line path altered");
	off_level_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		(!pwm_en && !int_en) [*2] |-> !AUXILIARY_MONITOR_OUTPUT)
		else $error("aux pin active while disabled");
	pin_owner_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		int_en |=> AUXILIARY_MONITOR_OUTPUT == $past(IRQ_IN))
		else $error("aux pin not following interrupt while enabled");
	apb_ready_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		acc_phase && !PREADY |=> PREADY ##1 !PREADY)
		else $error("apb ready not a single pulse after one wait");

	cover_mute_c: cover property (@(posedge SYS_CLK) disable iff (!RST_N)
		mod_cfg.en && rx_att_reg == '0 && tx_att_reg == '0);

endmodule : cpm_monitor_top

// ===== tb/cpm_speaker_model.sv
// speaker driver model: integrates drive time of the monitor pin
`timescale 1ns/1ps
module cpm_speaker_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic aux,
	input wire logic win,
	output int hi_cnt
);
	// ==========================================================
	// drive energy
	// transistor conducts while the pin is high; an unknown level counts so it cannot hide
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hi_cnt <= 0;
		end else if (!win) begin
			hi_cnt <= 0;
		end else if (aux !== 1'b0) begin
			hi_cnt <= hi_cnt + 1;
		end
	end
endmodule : cpm_speaker_model

// ===== tb/call_progress_pwm_output_bench.sv
// bench: register access, line path and monitor output modes
`timescale 1ns/1ps
module call_progress_pwm_output_bench;
	import cpm_pkg::*;
	localparam int P = 20;
	typedef struct packed {
		logic [9:0] addr;
		logic [7:0] wdata;
		logic [7:0] exp;
		logic err;
	} cpm_row_t;
	logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, irq_in = 0, win = 0;
	logic [9:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic pready, pslverr, aux, er;
	logic signed [15:0] rx = '0, tx = '0, rx_line, tx_line;
	int hi_cnt, err_total = 0, n_checks = 0, cyc = 0;
	cpm_row_t rows [6] = '{'{10'h004, 8'h38, 8'h38, 1'b0}, '{10'h008, 8'h01, 8'h01, 1'b0},
		'{10'h050, 8'hA5, 8'hA5, 1'b0}, '{10'h054, 8'h5A, 8'h5A, 1'b0},
		'{10'h00C, 8'h55, 8'h00, 1'b1}, '{10'h051, 8'h77, 8'h00, 1'b1}};

	cpm_monitor_top #(.PWM_PERIOD_CYC(P)) i_cpm_monitor_top (.SYS_CLK(clk), .RST_N(rst_n),
		.PADDR(paddr), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PWDATA(pwdata),
		.PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .RX_SAMPLE(rx), .TX_SAMPLE(tx),
		.IRQ_IN(irq_in), .RX_LINE_OUT(rx_line), .TX_LINE_OUT(tx_line),
		.AUXILIARY_MONITOR_OUTPUT(aux));
	cpm_speaker_model i_cpm_speaker_model (.clk(clk), .rst_n(rst_n), .aux(aux), .win(win),
		.hi_cnt(hi_cnt));

	initial begin
		forever #2.5 clk = ~clk;
	end

	task automatic report_and_stop();
		if (err_total == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : report_and_stop

	// ==========================================================
	// timeout
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			report_and_stop();
		end
	end

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			err_total++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// request held until ready is seen high; data taken for that edge
	task automatic apb(input logic wr, input logic [9:0] a, input logic [7:0] d);
		@(posedge clk);
		psel <= 1;
		penable <= 0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h00_0000, d};
		@(posedge clk);
		penable <= 1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask : apb

	task automatic cfg(input logic ie, input logic pe, input logic [1:0] m);
		apb(1, 10'h008, {7'h00, ie});
		apb(1, 10'h004, {2'h0, m, pe, 3'h0});
	endtask : cfg

	// waits out the duty latch, then counts high cycles over two frames
	task automatic measure(input string nm, input int e, input bit loose);
		repeat (3 * P) @(posedge clk);
		win <= 1;
		repeat (2 * P) @(posedge clk);
		win <= 0;
		@(negedge clk);
		chk(nm, e, (loose && hi_cnt >= e - 1 && hi_cnt <= e + 1) ? e : hi_cnt);
	endtask : measure

	// ==========================================================
	// main sequence
	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1;
		foreach (rows[i]) begin
			apb(0, rows[i].addr, 8'h00);
			chk("rst_val", 32'h0000_0000, rd);
		end
		foreach (rows[i]) begin
			apb(1, rows[i].addr, rows[i].wdata);
			apb(0, rows[i].addr, 8'h00);
			chk("rd_data", {24'h00_0000, rows[i].exp}, rd);
			chk("slv_err", {31'h0, rows[i].err}, {31'h0, er});
		end
		apb(0, 10'h050, 8'h00);
		chk("unaligned_wr", 32'h0000_00A5, rd);
		// interrupt function owns the pin even with pwm enabled
		irq_in <= 1;
		measure("irq_hi", 2 * P, 0);
		@(posedge clk);
		irq_in <= 0;
		measure("irq_lo", 0, 0);
		@(posedge clk);
		rx <= 16'h1234;
		tx <= 16'hEDCB;
		@(posedge clk);
		@(negedge clk);
		chk("rx_line", 32'h0000_1234, {16'h0000, rx_line});
		chk("tx_line", 32'h0000_EDCB, {16'h0000, tx_line});
		apb(1, 10'h050, 8'h00);
		apb(1, 10'h054, 8'h00);
		rx <= 16'h4000;
		tx <= 16'h4000;
		// both muted: mid-scale duty of half a frame whatever the samples, no high time in the off mode
		for (int m = 0; m < 4; m++) begin
			cfg(0, 1, m[1:0]);
			measure("mode_duty", (m == 3) ? 0 : P, m == 2);
		end
		cfg(0, 1, 2'h0);
		apb(1, 10'h050, 8'h80);
		measure("rx_gain", 24, 0);
		apb(1, 10'h054, 8'h80);
		measure("rx_tx_gain", 30, 0);
		chk("tx_line_gain", 32'h0000_4000, {16'h0000, tx_line});
		apb(1, 10'h050, 8'h00);
		measure("rx_muted", 24, 0);
		cfg(0, 0, 2'h0);
		measure("pwm_off", 0, 0);
		// status shows a running modulator, then a mid-run reset clears it all
		cfg(0, 1, 2'h0);
		apb(0, 10'h058, 8'h00);
		chk("status_run", 32'h0000_0002, rd & 32'h0000_0002);
		rst_n <= 0;
		@(posedge clk);
		@(negedge clk);
		chk("rst_aux", 32'h0000_0000, {31'h0, aux});
		chk("rst_line", 32'h0000_0000, {16'h0000, rx_line});
		@(posedge clk);
		rst_n <= 1;
		apb(0, 10'h004, 8'h00);
		chk("rst_ctrl", 32'h0000_0000, rd);
		measure("rst_pwm_off", 0, 0);
		report_and_stop();
	end
endmodule : call_progress_pwm_output_bench
